//--- rtcf_pkg.sv
// Shared constants and types of the frequency-test and battery-flag block
package rtcf_pkg;

    // System clock and oscillator rates
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned OSC_HZ = 32_768;
    localparam int unsigned TEST_HZ = 512;
    localparam int unsigned TEST_RATIO = OSC_HZ / TEST_HZ;
    localparam int unsigned TEST_HALF = TEST_RATIO / 2;

    // Supply settling time before the battery is judged
    localparam int unsigned SETTLE_US = 10;
    localparam int unsigned SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1_000_000) < 1)
        ? 1 : SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SETTLE_W = 8;

    // Register byte offsets
    localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
    localparam logic [31:0] STAT_OFS = 32'h0000_0004;
    localparam logic [31:0] IRQ_STAT_OFS = 32'h0000_0008;
    localparam logic [31:0] IRQ_MASK_OFS = 32'h0000_000C;
    localparam logic [31:0] MAP_MASK = 32'hFFFF_FFF0;

    // Control register fields
    localparam int unsigned CTRL_TEST_BIT = 0;
    localparam int unsigned CTRL_HALT_BIT = 1;
    localparam int unsigned CTRL_HOLD_BIT = 2;
    localparam int unsigned CTRL_TARM_BIT = 3;
    localparam int unsigned CTRL_SLEEP_BIT = 4;
    localparam int unsigned CTRL_CAL_LSB = 8;
    localparam int unsigned CAL_W = 6;

    // Status register fields
    localparam int unsigned STAT_BATT_BIT = 0;
    localparam int unsigned STAT_TF_BIT = 1;
    localparam int unsigned STAT_VCC_BIT = 2;
    localparam int unsigned STAT_PIN_BIT = 3;

    // Interrupt status and mask fields
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_BATT_BIT = 0;
    localparam int unsigned IRQ_TF_BIT = 1;
    localparam int unsigned IRQ_PF_BIT = 2;

    // Reset values
    localparam logic [CAL_W-1:0] CAL_RST = 6'h00;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // Supply state machine
    typedef enum logic [2:0] {
        PWR_DOWN = 3'b001,
        PWR_SETTLE = 3'b010,
        PWR_ON = 3'b100
    } rtcf_pwr_type;

endpackage

//--- rtcf_ft_div.sv
// Divider from the raw oscillator tick to the frequency-test square wave
`timescale 1ns/1ns
`default_nettype none

module rtcf_test_div
    import rtcf_pkg::*;
#(
    parameter int unsigned DIV = TEST_RATIO
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic osc_tick,
    input wire logic run,
    output logic wave_low_r
);

    localparam int unsigned HALF = DIV / 2;
    localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;

    generate
        if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
            $error("rtcf_test_div: DIV must be even and at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic low;
    } rtcf_div_state_type;

    rtcf_div_state_type state_r;
    rtcf_div_state_type state_nxt;

    // Raw count chain, calibration never enters here
    always_comb begin
        state_nxt = state_r;
        if (!run) begin
            state_nxt.cnt = '0;
            state_nxt.low = 1'b0;
        end else if (osc_tick) begin
            if (state_r.cnt == CW'(HALF - 1)) begin
                state_nxt.cnt = '0;
                state_nxt.low = ~state_r.low;
            end else begin
                state_nxt.cnt = state_r.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign wave_low_r = state_r.low;

endmodule

`default_nettype wire

//--- rtcf_top.sv
// Frequency-test output, battery-low flag and power defaults, AHB-Lite slave
//
// Function
// - Test pin toggles at 512 Hz while halt is 0 and test enable is 1.
// - Calibration value never changes the test output rate.
// - Test enable clears when main supply fails.
// - Each power-up checks the battery and sets the low flag below threshold.
// - Low flag stays set until a later power-up check finds a good battery.
// - Battery is judged only with main supply present, never on backup.
// - First attach clears write-clock hold and test enable.
// - Power cycle clears hold and test enable, keeps tamper, halt, sleep bits.
// - Low flag is read-only; host writes cannot change it.
`timescale 1ns/1ns
`default_nettype none

module rtcf_top
    import rtcf_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
    parameter int unsigned TEST_DIV = TEST_RATIO
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic osc_tick,
    input wire logic vcc_good,
    input wire logic battery_ok,
    input wire logic tamper_in,
    input wire logic test_pin_in,
    output logic test_pin_out,
    output logic test_pin_oe,
    output logic battery_low_flag,
    output logic oscillator_halt,
    output logic write_clock_hold,
    output logic sleep_select,
    output logic tamper_flag,
    output logic [CAL_W-1:0] calib_value,
    output logic irq
);

    generate
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << SETTLE_W))
        begin : g_bad_settle
            $error("rtcf_top: SETTLE_CYCLES out of counter range");
        end
    endgenerate

    typedef struct packed {
        rtcf_pwr_type pwr;
        logic [SETTLE_W-1:0] settle_cnt;
        logic freq_test_enable;
        logic oscillator_halt;
        logic write_clock_hold;
        logic tamper_arm;
        logic sleep_select;
        logic [CAL_W-1:0] calib;
        logic battery_low_flag;
        logic tamper_flag;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic wr_pend;
        logic [31:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
        logic irq;
    } rtcf_state_type;

    rtcf_state_type state_r;
    rtcf_state_type state_nxt;
    logic [1:0] rst_sync_r;
    logic rst_core_n;
    logic wave_low;
    logic wave_run;
    logic addr_take;
    logic wr_ctrl;
    logic wr_istat;
    logic wr_imask;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_core_n = rst_sync_r[1];

    // Test wave runs only with halt clear and enable set
    assign wave_run = state_r.freq_test_enable
        & ~state_r.oscillator_halt;

    // Divider sees only the raw tick, never the 6-bit calibration value
    rtcf_test_div #(
        .DIV(TEST_DIV)
    ) u_test_div (
        .ref_clk(ref_clk),
        .rst_n(rst_core_n),
        .osc_tick(osc_tick),
        .run(wave_run),
        .wave_low_r(wave_low)
    );

    function automatic logic [31:0] ctrl_word(input rtcf_state_type s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CTRL_TEST_BIT] = s.freq_test_enable;
        w[CTRL_HALT_BIT] = s.oscillator_halt;
        w[CTRL_HOLD_BIT] = s.write_clock_hold;
        w[CTRL_TARM_BIT] = s.tamper_arm;
        w[CTRL_SLEEP_BIT] = s.sleep_select;
        w[CTRL_CAL_LSB +: CAL_W] = s.calib;
        return w;
    endfunction

    function automatic logic [31:0] stat_word(input rtcf_state_type s,
                                              input logic vcc,
                                              input logic pin);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[STAT_BATT_BIT] = s.battery_low_flag;
        w[STAT_TF_BIT] = s.tamper_flag;
        w[STAT_VCC_BIT] = vcc;
        w[STAT_PIN_BIT] = pin;
        return w;
    endfunction

    assign addr_take = hsel & htrans[1] & hready;

    // Control writes only land while main supply is up
    assign wr_ctrl = state_r.wr_pend & (state_r.wr_addr == CTRL_OFS)
        & (state_r.pwr == PWR_ON);
    assign wr_istat = state_r.wr_pend & (state_r.wr_addr == IRQ_STAT_OFS);
    assign wr_imask = state_r.wr_pend & (state_r.wr_addr == IRQ_MASK_OFS);
    assign w1c = wr_istat ? hwdata[IRQ_W-1:0] : '0;

    always_comb begin
        state_nxt = state_r;
        ev = '0;
        state_nxt.ready = 1'b1;

        // Address phase: latch write target, prepare read data
        state_nxt.wr_pend = 1'b0;
        if (addr_take) begin
            state_nxt.wr_pend = hwrite;
            state_nxt.wr_addr = haddr;
            if (!hwrite) begin
                unique case (1'b1)
                    (haddr == CTRL_OFS):
                        state_nxt.rdata = ctrl_word(state_r);
                    (haddr == STAT_OFS):
                        state_nxt.rdata = stat_word(state_r, vcc_good,
                                                    test_pin_in);
                    (haddr == IRQ_STAT_OFS):
                        state_nxt.rdata = {{(32-IRQ_W){1'b0}},
                                           state_r.irq_stat};
                    (haddr == IRQ_MASK_OFS):
                        state_nxt.rdata = {{(32-IRQ_W){1'b0}},
                                           state_r.irq_mask};
                    default:
                        state_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Data phase: control and mask writes; status word holds no writable bit
        if (wr_ctrl) begin
            state_nxt.freq_test_enable = hwdata[CTRL_TEST_BIT];
            state_nxt.oscillator_halt = hwdata[CTRL_HALT_BIT];
            state_nxt.write_clock_hold = hwdata[CTRL_HOLD_BIT];
            state_nxt.tamper_arm = hwdata[CTRL_TARM_BIT];
            state_nxt.sleep_select = hwdata[CTRL_SLEEP_BIT];
            state_nxt.calib = hwdata[CTRL_CAL_LSB +: CAL_W];
        end
        if (wr_imask) begin
            state_nxt.irq_mask = hwdata[IRQ_W-1:0];
        end

        // Supply sequencing and battery check
        unique case (state_r.pwr)
            PWR_DOWN: begin
                state_nxt.freq_test_enable = 1'b0;
                state_nxt.write_clock_hold = 1'b0;
                state_nxt.settle_cnt = '0;
                if (vcc_good) begin
                    state_nxt.pwr = PWR_SETTLE;
                end
            end
            PWR_SETTLE: begin
                state_nxt.freq_test_enable = 1'b0;
                state_nxt.write_clock_hold = 1'b0;
                if (!vcc_good) begin
                    state_nxt.pwr = PWR_DOWN;
                end else if (state_r.settle_cnt ==
                             SETTLE_W'(SETTLE_CYCLES - 1)) begin
                    // Judged once per power-up, held otherwise
                    state_nxt.battery_low_flag = ~battery_ok;
                    ev[IRQ_BATT_BIT] = ~battery_ok;
                    state_nxt.pwr = PWR_ON;
                end else begin
                    state_nxt.settle_cnt = state_r.settle_cnt + SETTLE_W'(1);
                end
            end
            PWR_ON: begin
                if (!vcc_good) begin
                    state_nxt.freq_test_enable = 1'b0;
                    state_nxt.write_clock_hold = 1'b0;
                    ev[IRQ_PF_BIT] = 1'b1;
                    state_nxt.pwr = PWR_DOWN;
                end
            end
            default: begin
                state_nxt.pwr = PWR_DOWN;
            end
        endcase

        // Tamper latch works on backup too; set beats clear
        if (!state_nxt.tamper_arm && !tamper_in) begin
            state_nxt.tamper_flag = 1'b0;
        end
        if (state_r.tamper_arm && tamper_in) begin
            state_nxt.tamper_flag = 1'b1;
            ev[IRQ_TF_BIT] = ~state_r.tamper_flag;
        end

        // Sticky events, write one to clear, new event wins
        state_nxt.irq_stat = (state_r.irq_stat & ~w1c) | ev;
        state_nxt.irq = |(state_nxt.irq_stat & state_nxt.irq_mask);
    end

    // First attach: hold and test enable clear, other bits start at zero except pwr, which starts at one-hot PWR_DOWN
    always_ff @(posedge ref_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state_r <= '{
                pwr: PWR_DOWN,
                settle_cnt: '0,
                freq_test_enable: 1'b0,
                oscillator_halt: 1'b0,
                write_clock_hold: 1'b0,
                tamper_arm: 1'b0,
                sleep_select: 1'b0,
                calib: CAL_RST,
                battery_low_flag: 1'b0,
                tamper_flag: 1'b0,
                irq_stat: '0,
                irq_mask: IRQ_MASK_RST,
                wr_pend: 1'b0,
                wr_addr: 32'h0000_0000,
                rdata: 32'h0000_0000,
                ready: 1'b0,
                irq: 1'b0
            };
        end else begin
            state_r <= state_nxt;
        end
    end

    // Bus answers, always OKAY, zero wait
    assign hreadyout = state_r.ready;
    assign hresp = 1'b0;
    assign hrdata = state_r.rdata;

    // Open drain test pin pulls low only
    assign test_pin_out = 1'b0;
    assign test_pin_oe = wave_low;

    // Flag mirrors, none writable through the status word
    assign battery_low_flag = state_r.battery_low_flag;
    assign oscillator_halt = state_r.oscillator_halt;
    assign write_clock_hold = state_r.write_clock_hold;
    assign sleep_select = state_r.sleep_select;
    assign tamper_flag = state_r.tamper_flag;
    assign calib_value = state_r.calib;
    assign irq = state_r.irq;

    // Size field unused: only whole-word transfers reach this slave
    logic unused_hsize;
    assign unused_hsize = ^hsize;

endmodule

`default_nettype wire

//--- rtcf_chk.sv
// Port assertions of the test-output and battery-flag block
`timescale 1ns/1ns
`default_nettype none
module rtcf_chk
    import rtcf_pkg::*;
#(
    parameter int unsigned TEST_DIV = TEST_RATIO
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic osc_tick,
    input wire logic vcc_good,
    input wire logic battery_ok,
    input wire logic test_pin_oe,
    input wire logic battery_low_flag,
    input wire logic oscillator_halt,
    input wire logic write_clock_hold,
    input wire logic sleep_select,
    input wire logic [CAL_W-1:0] calib_value
);
    localparam int HALF = TEST_DIV / 2;
    logic oe_q;
    logic [7:0] tick_cnt;
    // Ticks seen since the last pin change, saturating
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
            tick_cnt <= 8'h00;
        end else begin
            oe_q <= test_pin_oe;
            if (test_pin_oe != oe_q) begin
                tick_cnt <= {7'h00, osc_tick};
            end else if (osc_tick && tick_cnt != 8'hFF) begin
                tick_cnt <= tick_cnt + 8'h01;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_halt_no_wave: assert property (
        oscillator_halt && $past(oscillator_halt) |-> !test_pin_oe)
        else $error("test pin pulled while halted");
    a_wave_half: assert property (
        $rose(test_pin_oe) |-> $past(osc_tick) && tick_cnt >= HALF)
        else $error("test pin half period too short");
    a_hold_down: assert property (
        !vcc_good && $past(!vcc_good) |-> !write_clock_hold)
        else $error("write clock hold set without supply");
    a_flag_backup: assert property (
        !vcc_good |=> $stable(battery_low_flag))
        else $error("battery flag moved on backup");
    a_keep_bits: assert property (
        $past(!vcc_good) && $past(!vcc_good, 2) |->
        $stable(oscillator_halt) && $stable(sleep_select) &&
        $stable(calib_value))
        else $error("kept control bits changed while down");
    a_low_cause: assert property (
        $rose(battery_low_flag) |-> $past(!battery_ok) && $past(vcc_good))
        else $error("battery flag set without low battery");
    a_clear_cause: assert property (
        $fell(battery_low_flag) |-> $past(battery_ok) && $past(vcc_good))
        else $error("battery flag cleared without good check");
    a_ready_okay: assert property (
        $past(hreadyout) |-> hreadyout && !hresp)
        else $error("bus ready dropped or error response");
    c_flag_set: cover property ($rose(battery_low_flag));
    c_flag_clear: cover property ($fell(battery_low_flag));
    c_wave: cover property ($rose(test_pin_oe));
endmodule
bind rtcf_top rtcf_chk #(.TEST_DIV(TEST_DIV)) chk_u (.ref_clk, .rst_n,
    .hreadyout, .hresp, .osc_tick, .vcc_good, .battery_ok, .test_pin_oe,
    .battery_low_flag, .oscillator_halt, .write_clock_hold,
    .sleep_select, .calib_value);
`default_nettype wire

//--- rtcf_host.sv
// Host model: AHB-Lite single-word master
`timescale 1ns/1ns
`default_nettype none
module rtcf_host
    import rtcf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    int n_late = 0;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic wait_ready();
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (hready === 1'b1) break;
        end
        if (i == 20) n_late++;
    endtask
    task automatic xfer(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask
    // Tamper arm starts at zero from reset; the control word is still cleared first
    task automatic attach_init();
        logic [31:0] q;
        xfer(1'b1, CTRL_OFS, 32'h0, q);
    endtask
endmodule
`default_nettype wire

//--- rtcf_freq_test_battery_flag_tb.sv
// Testbench of the test-output and battery-flag block
`timescale 1ns/1ns
`default_nettype none
module rtcf_freq_test_battery_flag_tb;
    import rtcf_pkg::*;
    logic ref_clk = 1'b0;
    logic osc_tick = 1'b0;
    logic [2:0] tdiv = 3'h0;
    logic rst_n, hsel, hwrite, hreadyout, hresp;
    logic vcc_good, battery_ok, tamper_in, test_pin_in, test_pin_out;
    logic test_pin_oe, battery_low_flag, oscillator_halt, write_clock_hold;
    logic sleep_select, tamper_flag, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [CAL_W-1:0] calib_value;
    int n_mismatch = 0;
    int n_compared = 0;
    int c;
    assign test_pin_in = test_pin_oe ? test_pin_out : 1'b1;
    rtcf_top #(.SETTLE_CYCLES(2), .TEST_DIV(4)) dut_u (.ref_clk, .rst_n,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .osc_tick, .vcc_good, .battery_ok,
        .tamper_in, .test_pin_in, .test_pin_out, .test_pin_oe,
        .battery_low_flag, .oscillator_halt, .write_clock_hold,
        .sleep_select, .tamper_flag, .calib_value, .irq);
    rtcf_host host_u (.ref_clk, .hready(hreadyout), .hrdata, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata);
    always #50 ref_clk = ~ref_clk;
    // Oscillator tick every 8 clocks
    always @(posedge ref_clk) begin
        tdiv <= tdiv + 3'h1;
        osc_tick <= (tdiv == 3'h7);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        host_u.xfer(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d, q);
    endtask
    task automatic wait_flag(input logic v);
        int i;
        for (i = 0; i < 50 && battery_low_flag !== v; i++) begin
            @(posedge ref_clk);
        end
        chk({31'h0, battery_low_flag}, {31'h0, v});
    endtask
    // Clocks until the test pin next goes from released to pulled
    task automatic rise(output int n);
        n = 0;
        while (test_pin_oe !== 1'b0 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        while (test_pin_oe !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
    endtask
    task automatic summarize();
        n_mismatch += host_u.n_late;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        vcc_good = 1'b0;
        battery_ok = 1'b0;
        tamper_in = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        vcc_good <= 1'b1;
        wait_flag(1'b1);
        host_u.attach_init();
        rd_chk(STAT_OFS, 32'hD);
        wr(STAT_OFS, 32'h0);
        rd_chk(STAT_OFS, 32'hD);
        rd_chk(IRQ_STAT_OFS, 32'h1);
        wr(IRQ_MASK_OFS, 32'h1);
        rd_chk(IRQ_MASK_OFS, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_STAT_OFS, 32'h1);
        rd_chk(IRQ_STAT_OFS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd_chk(32'h10, 32'h0);
        $display("test battery check done");
        for (int k = 0; k < 2; k++) begin
            wr(CTRL_OFS, k == 0 ? 32'h0001 : 32'h3F01);
            rise(c);
            rise(c);
            chk(c, 32);
        end
        rd_chk(CTRL_OFS, 32'h3F01);
        wr(CTRL_OFS, 32'h2A1F);
        // Pin is released one edge after halt lands
        @(posedge ref_clk);
        c = 0;
        repeat (100) begin
            @(posedge ref_clk);
            if (test_pin_oe !== 1'b0) c++;
        end
        chk(c, 0);
        chk({31'h0, write_clock_hold}, 32'h1);
        $display("test wave done");
        vcc_good <= 1'b0;
        battery_ok <= 1'b1;
        tamper_in <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({22'h0, tamper_flag, oscillator_halt, sleep_select,
            write_clock_hold, calib_value}, 32'h3AA);
        wr(CTRL_OFS, 32'h0);
        repeat (20) @(posedge ref_clk);
        chk({31'h0, battery_low_flag}, 32'h1);
        vcc_good <= 1'b1;
        wait_flag(1'b0);
        rd_chk(CTRL_OFS, 32'h2A1A);
        rd_chk(STAT_OFS, 32'hE);
        rd_chk(IRQ_STAT_OFS, 32'h6);
        tamper_in <= 1'b0;
        wr(CTRL_OFS, 32'h0);
        rd_chk(STAT_OFS, 32'hC);
        $display("test power cycle done");
        summarize();
    end
endmodule
`default_nettype wire
